// ---- rtl/wdc_pkg.sv ----
// constants of the watchdog control block: register map, field layout, time-out table
// assumes one 10 MHz system clock; oscillator ticks arrive as a synchronous strobe
// Behaviour
// RL1 - reset_enable may be cleared or timeout_select changed only while change_unlock is set.
// RL2 - change_unlock clears itself four system clock cycles after it was written to one.
// RL3 - reset_enable reads and acts as one while the watchdog reset flag is set.
// RL4 - software clears the watchdog reset flag before it tries to clear reset_enable.
// RL5 - timeout_select has its top bit at position 5 and its low three bits at 2:0.
// RL6 - time-out is 2048 oscillator cycles at code zero, doubling up to 1048576 at nine.
// RL7 - a watchdog system reset goes out on the common reset vector, vector number 1.
// RL8 - software writes change_unlock and reset_enable high together, then the new values.
// RL9 - reset_enable and interrupt_enable pick stopped, interrupt, reset or both modes.
// RL10 - timeout_flag sets on an interrupt time-out, clears on vector fetch or written one.
// RL11 - with the always-on fuse programmed, reset mode is forced, interrupt off.
// RL12 - the counter restarts on a watchdog-reset instruction and times out at the period.
package wdc_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00; // control and status byte
    localparam logic [7:0] RSTS_OFS = 8'h04; // reset status register
    localparam logic [7:0] ISTAT_OFS = 8'h08; // sticky event status, read only
    localparam logic [7:0] ICLR_OFS = 8'h0c; // event clear, write one
    localparam logic [7:0] IEN_OFS = 8'h10; // event enable
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int SEL3_BIT = 5;
    localparam int UNLK_BIT = 4;
    localparam int RE_BIT = 3;
    localparam int WRF_BIT = 3; // position inside reset status register
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int UNLOCK_CYCLES = 4;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int BASE_LOG2 = 11; // 2048 cycles at code zero
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [7:0] RESET_VECTOR = 8'h01;
    typedef enum logic [1:0] {
        WDC_STOP = 2'b00,
        WDC_IRQ = 2'b01,
        WDC_RST = 2'b10,
        WDC_BOTH = 2'b11
    } wdc_mode_e;
endpackage

// ---- rtl/wdc_watchdog.sv ----
// watchdog control: AXI4-Lite slave, timed unlock, mode decode, time-out counter
// assumes osc_tick is a one-cycle strobe per oscillator cycle, synchronous to core_clk
module wdc_watchdog
    import wdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic fuse_prog, // always-on fuse programmed
    input wire logic osc_tick,
    input wire logic wdr_pulse, // watchdog-reset instruction
    input wire logic vec_ack, // timeout interrupt vector executed
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic wdt_irq_req,
    output logic sys_reset_req,
    output logic [7:0] reset_vector
);
    logic rstSync1_ff, rstSync2_ff, rstB;
    // two-flop release so the block leaves reset cleanly on a clock edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    assign rstB = rstSync2_ff;

    // write channel capture: address and data may arrive in either order
    logic awHeld_ff, wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic wrFire, wrCtrl, wrRsts, wrClr, wrEn, wrMapped, byte0;
    assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
    assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign byte0 = wStrb_ff[0];
    assign wrCtrl = wrFire && byte0 && (awAddr_ff == CTRL_OFS);
    assign wrRsts = wrFire && byte0 && (awAddr_ff == RSTS_OFS);
    assign wrClr = wrFire && byte0 && (awAddr_ff == ICLR_OFS);
    assign wrEn = wrFire && byte0 && (awAddr_ff == IEN_OFS);
    assign wrMapped = (awAddr_ff == CTRL_OFS) || (awAddr_ff == RSTS_OFS) ||
                      (awAddr_ff == ISTAT_OFS) || (awAddr_ff == ICLR_OFS) ||
                      (awAddr_ff == IEN_OFS);

    always_ff @(posedge core_clk or negedge rstB) begin
        if (!rstB) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control state
    logic flag_ff, ie_ff, re_ff, unlk_ff, wrf_ff, tmo_ff;
    logic [3:0] sel_ff;
    logic [2:0] unlkCnt_ff;
    logic [20:0] cnt_ff;
    logic [1:0] evSt_ff, evEn_ff;
    logic [7:0] wb;
    logic reEff, ieEff, timeout, flagSet, rstEvent, accessOk;
    wdc_mode_e mode;
    assign wb = wData_ff[7:0];
    assign accessOk = unlk_ff; // RL1
    assign reEff = re_ff || wrf_ff || fuse_prog; // RL3 RL11
    assign ieEff = ie_ff && !fuse_prog; // RL11
    assign mode = wdc_mode_e'({reEff, ieEff}); // RL9

    // period decode; reserved select codes behave as the longest period
    function automatic logic [20:0] period_of(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > SEL_MAX) ? SEL_MAX : sel;
        period_of = 21'(21'h1 << (BASE_LOG2 + int'(s)));
    endfunction
    assign timeout = osc_tick && (mode != WDC_STOP) &&
                     (cnt_ff == period_of(sel_ff) - 21'h1); // RL6 RL12
    assign flagSet = timeout && ((mode == WDC_IRQ) || (mode == WDC_BOTH && !flag_ff)); // RL10
    assign rstEvent = timeout && ((mode == WDC_RST) || (mode == WDC_BOTH && flag_ff)); // RL9

    // counter runs on oscillator ticks, restarts on the instruction or a time-out
    always_ff @(posedge core_clk or negedge rstB) begin
        if (!rstB) begin
            cnt_ff <= 21'h0;
        end else if (wdr_pulse || timeout || mode == WDC_STOP) begin
            cnt_ff <= 21'h0; // RL12
        end else if (osc_tick) begin
            cnt_ff <= cnt_ff + 21'h1;
        end
    end

    // register updates; hardware sets win over software clears
    always_ff @(posedge core_clk or negedge rstB) begin
        if (!rstB) begin
            flag_ff <= CTRL_RST[FLAG_BIT];
            ie_ff <= CTRL_RST[IE_BIT];
            re_ff <= CTRL_RST[RE_BIT];
            unlk_ff <= CTRL_RST[UNLK_BIT];
            sel_ff <= {CTRL_RST[SEL3_BIT], CTRL_RST[2:0]};
            unlkCnt_ff <= 3'h0;
            wrf_ff <= 1'b0;
            tmo_ff <= 1'b0;
            evSt_ff <= 2'b00;
            evEn_ff <= 2'b00;
        end else begin
            tmo_ff <= rstEvent;
            if (flagSet) begin
                flag_ff <= 1'b1;
            end else if (vec_ack || (wrCtrl && wb[FLAG_BIT])) begin
                flag_ff <= 1'b0; // RL10
            end
            if (vec_ack && mode == WDC_BOTH) begin
                ie_ff <= 1'b0; // back to reset mode after the serviced interrupt
            end else if (wrCtrl) begin
                ie_ff <= wb[IE_BIT];
            end
            if (wrCtrl) begin
                // setting reset_enable is always allowed, clearing needs unlock
                if (wb[RE_BIT] || accessOk) begin
                    re_ff <= wb[RE_BIT]; // RL1 RL8
                end
                if (accessOk) begin
                    sel_ff <= {wb[SEL3_BIT], wb[2:0]}; // RL1 RL5
                end
            end
            if (wrCtrl && wb[UNLK_BIT] && wb[RE_BIT]) begin
                unlk_ff <= 1'b1; // RL8
                unlkCnt_ff <= 3'(UNLOCK_CYCLES);
            end else if (unlkCnt_ff != 3'h0) begin
                unlkCnt_ff <= unlkCnt_ff - 3'h1;
                unlk_ff <= (unlkCnt_ff != 3'h1); // RL2
            end else if (wrCtrl) begin
                unlk_ff <= 1'b0;
            end
            if (rstEvent) begin
                wrf_ff <= 1'b1;
            end else if (wrRsts && !wb[WRF_BIT]) begin
                wrf_ff <= 1'b0; // RL4
            end
            if (wrEn) begin
                evEn_ff <= wb[1:0];
            end
            evSt_ff <= (evSt_ff & ~(wrClr ? wb[1:0] : 2'b00)) | {rstEvent, flagSet};
        end
    end

    assign irq = |(evSt_ff & evEn_ff);
    assign wdt_irq_req = flag_ff && ieEff;
    assign sys_reset_req = tmo_ff; // RL7
    assign reset_vector = RESET_VECTOR; // RL7

    // read channel
    logic [7:0] rdByte;
    assign rdByte = (s_axi_araddr == CTRL_OFS) ?
                        {flag_ff, ieEff, sel_ff[3], unlk_ff, reEff, sel_ff[2:0]} :
                    (s_axi_araddr == RSTS_OFS) ? {4'h0, wrf_ff, 3'h0} :
                    (s_axi_araddr == ISTAT_OFS) ? {6'h00, evSt_ff} :
                    (s_axi_araddr == IEN_OFS) ? {6'h00, evEn_ff} : 8'h00;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or negedge rstB) begin
        if (!rstB) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rdByte};
            s_axi_rresp <= (s_axi_araddr == CTRL_OFS || s_axi_araddr == RSTS_OFS ||
                            s_axi_araddr == ISTAT_OFS || s_axi_araddr == ICLR_OFS ||
                            s_axi_araddr == IEN_OFS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    property p_unlock_close;
        @(posedge core_clk) disable iff (!rstB)
        (wrCtrl && wb[UNLK_BIT] && wb[RE_BIT]) |=> unlk_ff [*4] ##1 !unlk_ff;
    endproperty
    a_unlock_close: assert property (p_unlock_close) else $error("unlock window wrong"); // RL2
    property p_locked_sel;
        @(posedge core_clk) disable iff (!rstB)
        !unlk_ff |=> $stable(sel_ff);
    endproperty
    a_locked_sel: assert property (p_locked_sel) else $error("select changed locked"); // RL1
    // watched on the read data, so a broken read mux cannot hide behind reEff
    property p_flag_forces_re;
        @(posedge core_clk) disable iff (!rstB)
        (wrf_ff && s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_OFS) |=>
            s_axi_rdata[RE_BIT];
    endproperty
    a_flag_forces_re: assert property (p_flag_forces_re) else $error("re not forced"); // RL3
    property p_fuse;
        @(posedge core_clk) disable iff (!rstB)
        fuse_prog |-> (mode == WDC_RST);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse mode wrong"); // RL11
    property p_irq_flag;
        @(posedge core_clk) disable iff (!rstB)
        (timeout && mode == WDC_IRQ) |=> flag_ff;
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("flag not set"); // RL10
    property p_reset_out;
        @(posedge core_clk) disable iff (!rstB)
        rstEvent |=> sys_reset_req && wrf_ff;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset not issued"); // RL7
    property p_wdr;
        @(posedge core_clk) disable iff (!rstB)
        wdr_pulse |=> cnt_ff == 21'h0;
    endproperty
    a_wdr: assert property (p_wdr) else $error("count not restarted"); // RL12
    property p_sel_map;
        @(posedge core_clk) disable iff (!rstB)
        (wrCtrl && unlk_ff) |=> sel_ff == {$past(wb[SEL3_BIT]), $past(wb[2:0])};
    endproperty
    a_sel_map: assert property (p_sel_map) else $error("select layout wrong"); // RL5
    c_timeout: cover property (@(posedge core_clk) disable iff (!rstB) timeout);
    c_reset: cover property (@(posedge core_clk) disable iff (!rstB) rstEvent);
    c_unlock: cover property (@(posedge core_clk) disable iff (!rstB) wrCtrl && unlk_ff);
endmodule

// ---- sim/test_watchdog_timed_control.sv ----
// self-checking bench for the watchdog control block, driven over AXI4-Lite
// assumes wdc_watchdog as the device under test; the bench drives every port itself
module test_watchdog_timed_control
    import wdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst_b = 0, fuse_prog = 0, osc_tick = 0, wdr_pulse = 0, vec_ack = 0;
    logic [7:0] awAddr = 0, arAddr = 0, resetVector;
    logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic [31:0] wData = 0, rData, rd;
    logic awReady, wReady, bValid, arReady, rValid, irq, wdtIrq, sysRst;
    logic [1:0] bResp, rResp, rs;
    int errors = 0, cmp_count = 0, cycles = 0, n;

    wdc_watchdog wdc_watchdog_inst (.core_clk(core_clk), .rst_b(rst_b),
        .fuse_prog(fuse_prog), .osc_tick(osc_tick), .wdr_pulse(wdr_pulse),
        .vec_ack(vec_ack), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .irq(irq), .wdt_irq_req(wdtIrq), .sys_reset_req(sysRst),
        .reset_vector(resetVector));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // hang guard: the tests need roughly 16000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // handshakes are sampled at the falling edge so combinational readies are settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(negedge core_clk);
            aw = awValid && awReady;
            w = wValid && wReady;
            b = bValid;
            rs = bResp;
            @(posedge core_clk);
            if (aw) awValid <= 1'b0;
            if (w) wValid <= 1'b0;
        end while (!b);
        // bready stays high between writes; each call sets it high again, which changes nothing
    endtask

    task automatic rdr(input logic [7:0] a);
        logic ar, r;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(negedge core_clk);
            ar = arValid && arReady;
            r = rValid;
            rd = rData;
            rs = rResp;
            @(posedge core_clk);
            if (ar) arValid <= 1'b0;
        end while (!r);
        // rready stays high between reads for the same reason
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask

    task automatic pin(input logic v, input logic e);
        @(negedge core_clk);
        chk({31'h0, v}, {31'h0, e});
        @(posedge core_clk);
    endtask

    // restart the count, then tick every cycle until the chosen event shows
    task automatic run(input bit rstEvt, output int k);
        wdr_pulse <= 1'b1;
        @(posedge core_clk);
        wdr_pulse <= 1'b0;
        osc_tick <= 1'b1;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (!(rstEvt ? sysRst : wdtIrq) && k < 9000);
        @(posedge core_clk);
        osc_tick <= 1'b0;
    endtask

    // a few cycles of slack cover the strobe-to-flag pipeline
    task automatic near(input int k, input int e);
        chk((k >= e - 4 && k <= e + 12) ? e : k, e);
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        rchk(CTRL_OFS, {24'h0, CTRL_RST});
        chk({24'h0, resetVector}, {24'h0, RESET_VECTOR});
        rdr(8'h40);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h00);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        $display("test defaults done");
        wr(CTRL_OFS, 32'h08);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        wr(CTRL_OFS, 32'h01);
        rchk(CTRL_OFS, 32'h08);
        wr(CTRL_OFS, 32'h18);
        wr(CTRL_OFS, 32'h21);
        repeat (6) @(posedge core_clk);
        rchk(CTRL_OFS, 32'h21);
        wr(CTRL_OFS, 32'h39);
        repeat (8) @(posedge core_clk);
        rchk(CTRL_OFS, 32'h29);
        wr(CTRL_OFS, 32'h00);
        rchk(CTRL_OFS, 32'h29);
        $display("test unlock done");
        // early ticks must be discarded by the restart
        wr(CTRL_OFS, 32'h39);
        wr(CTRL_OFS, 32'h08);
        osc_tick <= 1'b1;
        repeat (1000) @(posedge core_clk);
        run(1'b1, n);
        near(n, 2048);
        rchk(RSTS_OFS, 32'h08);
        wr(CTRL_OFS, 32'h18);
        wr(CTRL_OFS, 32'h00);
        rchk(CTRL_OFS, 32'h08);
        wr(RSTS_OFS, 32'h00);
        wr(CTRL_OFS, 32'h18);
        wr(CTRL_OFS, 32'h01);
        repeat (6) @(posedge core_clk);
        rchk(CTRL_OFS, 32'h01);
        $display("test reset mode done");
        wr(ICLR_OFS, 32'h03);
        wr(IEN_OFS, 32'h01);
        wr(CTRL_OFS, 32'h41);
        run(1'b0, n);
        near(n, 4096);
        rchk(CTRL_OFS, 32'hc1);
        rchk(ISTAT_OFS, 32'h01);
        pin(irq, 1'b1);
        wr(IEN_OFS, 32'h00);
        pin(irq, 1'b0);
        wr(ICLR_OFS, 32'h01);
        rchk(ISTAT_OFS, 32'h00);
        wr(CTRL_OFS, 32'hc1);
        rchk(CTRL_OFS, 32'h41);
        pin(wdtIrq, 1'b0);
        $display("test interrupt mode done");
        wr(CTRL_OFS, 32'h49);
        run(1'b0, n);
        near(n, 4096);
        vec_ack <= 1'b1;
        @(posedge core_clk);
        vec_ack <= 1'b0;
        rchk(CTRL_OFS, 32'h09);
        run(1'b1, n);
        near(n, 4096);
        rchk(ISTAT_OFS, 32'h03);
        $display("test both mode done");
        wr(RSTS_OFS, 32'h00);
        fuse_prog <= 1'b1;
        wr(CTRL_OFS, 32'h19);
        wr(CTRL_OFS, 32'h41);
        rchk(CTRL_OFS, 32'h09);
        $display("test fuse done");
        report_and_stop();
    end
endmodule
